// File: design/fss_pkg.sv
// Purpose: constants and carrier types of the frequency sweep sequencer
// Assumes: frequencies in 10 mHz units, times in whole milliseconds
// Notes:   shared by the sequencer top and its assertions
// How it works
// - continuous mode starts on menu exit
// - continue type holds stop frequency afterwards
// - stop type halts at set phase
// - trigger edge starts sweep, ignored mid-sweep
// - manual key starts sweep like trigger
// - triggered mode ignores repeat interval
// - gate starts sweep, holds stop frequency
// - gate release halts at set phase
// - log gated sweep restarts from start
// - linear gated sweep may resume midway
// - gated mode ignores type and interval
// - short sweep display alternates start/stop
// - long sweep display shows live frequency
// - law is linear or logarithmic only
// - start range depends on waveform class
// - five digits, 10 mHz step
// - edit refuses, direct entry clamps nearer
// - stop range equals start range
// - direction from start/stop, equal no sweep
// - sweep time 1 ms to 500 s
// - linear down short sweep: time >= 2/stop
// - interval 1 ms to 500 s, may double
// - sync high while frequency travels
// - marker high until marker frequency reached
package fss_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int DISP_ALT_MS   = 500;
  // ---------------------------------------------------------------
  // widths and limits
  // ---------------------------------------------------------------
  localparam int FW = 32;
  localparam int TW = 19;
  localparam int NW = FW + TW;
  localparam logic [FW-1:0] FREQ_MIN      = 32'h0000_0001;  // 10 mHz
  localparam logic [FW-1:0] FREQ_MAX_WIDE = 32'h5968_2F00;  // 15.0000 MHz
  localparam logic [FW-1:0] FREQ_MAX_NARR = 32'h0098_9680;  // 100.000 kHz
  localparam logic [FW-1:0] TIME_MIN      = 32'h0000_0001;  // 1 ms
  localparam logic [FW-1:0] TIME_MAX      = 32'h0007_A120;  // 500 s
  localparam logic [TW-1:0] ONE_S_MS      = 19'h003E8;
  localparam logic [NW-1:0] TWO_OVER_K    = 51'h0_0000_0003_0D40;  // 2 stop periods in ms*10mHz
  localparam logic [TW-1:0] DISP_ALT      = 19'(DISP_ALT_MS);
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [FW-1:0] RST_START  = 32'h0001_86A0;  // 1.0000 kHz
  localparam logic [FW-1:0] RST_STOP   = 32'h000F_4240;  // 10.000 kHz
  localparam logic [FW-1:0] RST_MARK   = 32'h0007_A120;  // 5.0000 kHz
  localparam logic [TW-1:0] RST_TIME   = 19'h00064;      // 100 ms
  localparam logic [TW-1:0] RST_INTVL  = 19'h000C8;      // 200 ms
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MODE_CONTINUOUS_OSCILLATION_MODE, MODE_TRIGGERED_OSCILLATION_MODE, MODE_GATE} fss_mode_type;
  typedef enum logic {LAW_LINEAR, LAW_LOG} fss_law_type;
  typedef enum logic {AFTER_CONTINUE, AFTER_STOP} fss_after_type;
  typedef enum logic [2:0] {F_START, F_STOP, F_MARK, F_TIME, F_INTVL} fss_field_type;
  typedef struct packed {
    logic          valid;
    fss_field_type field;
    logic          direct;   // keypad entry, else digit edit
    logic [FW-1:0] value;
  } fss_write_type;
  typedef struct packed {
    logic [FW-1:0] start;
    logic [FW-1:0] stop;
    logic [FW-1:0] mark;
    logic [TW-1:0] time_ms;
    logic [TW-1:0] intvl_ms;
  } fss_cfg_type;
endpackage

// File: design/fss_sequencer.sv
// Purpose: frequency sweep sequencer, settings store and sweep engine
// Assumes: all inputs but arst_n synchronous to core_clk, gate/trigger active high
// Notes:   log law uses a piecewise-linear log2 approximation
`timescale 1ns/1ns
`default_nettype none
module fss_sequencer
  import fss_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  // configuration
  input  wire logic          sweep_enable,
  input  wire logic          menu_exit,
  input  wire fss_mode_type  osc_mode,
  input  wire fss_law_type   sweep_law,
  input  wire fss_after_type after_type,
  input  wire logic          wave_narrow,
  input  wire fss_write_type cfg_write,
  // start sources
  input  wire logic          external_start_input,
  input  wire logic          manual_start_key,
  // outputs
  output var  fss_cfg_type   cfg,
  output logic               cfg_refused,
  output logic [FW-1:0]      out_freq,
  output logic [FW-1:0]      display_freq,
  output logic               osc_run,
  output logic               phase_halt,
  output logic               sweep_sync,
  output logic               sweep_marker
);
  typedef enum logic [1:0] {S_IDLE, S_SWEEP, S_HOLD, S_HALT} fss_state_type;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [FW-1:0] log2_approx(input logic [FW-1:0] x);
    logic [4:0]    msb;
    logic [FW-1:0] sh;
    msb = 5'h00;
    for (int i = 0; i < FW; i++) begin
      if (x[i]) begin
        msb = 5'(i);
      end
    end
    sh = x << (5'h1F - msb);
    return {11'h000, msb, sh[30:15]};
  endfunction

  function automatic logic [FW-1:0] exp2_approx(input logic [FW-1:0] l);
    logic [47:0] m;
    m = {31'h0000_0000, 1'b1, l[15:0]} << l[20:16];
    return m[47:16];
  endfunction

  // ---------------------------------------------------------------
  // settings store
  // ---------------------------------------------------------------
  fss_cfg_type   next_cfg;
  fss_cfg_type   cand;
  logic          next_cfg_refused;
  logic [FW-1:0] lo;
  logic [FW-1:0] hi;
  logic [FW-1:0] val;
  logic          ok;
  logic [NW-1:0] t_by_f;

  // limits per field; stop shares start range
  always_comb begin
    lo = FREQ_MIN;
    hi = wave_narrow ? FREQ_MAX_NARR : FREQ_MAX_WIDE;
    if (cfg_write.field == F_TIME || cfg_write.field == F_INTVL) begin
      lo = TIME_MIN;
      hi = TIME_MAX;
    end
    // edit refuses, keypad clamps to nearer limit
    ok  = 1'b1;
    val = cfg_write.value;
    if (cfg_write.value < lo) begin
      ok  = cfg_write.direct;
      val = lo;
    end else if (cfg_write.value > hi) begin
      ok  = cfg_write.direct;
      val = hi;
    end
    cand = cfg;
    case (cfg_write.field)
      F_START: cand.start    = val;
      F_STOP:  cand.stop     = val;
      F_MARK:  cand.mark     = val;
      F_TIME:  cand.time_ms  = val[TW-1:0];
      F_INTVL: cand.intvl_ms = val[TW-1:0];
      default: ok = 1'b0;
    endcase
    // short linear down sweep must last two stop periods
    t_by_f = NW'(cand.time_ms) * NW'(cand.stop);
    if (sweep_law == LAW_LINEAR && cand.stop < cand.start &&
        cand.time_ms < ONE_S_MS && t_by_f < TWO_OVER_K) begin
      ok = 1'b0;
    end
    next_cfg         = (cfg_write.valid && ok) ? cand : cfg;
    next_cfg_refused = cfg_write.valid && !ok;
  end

  // settings register; 10 mHz units, no digit rounding
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg         <= '{RST_START, RST_STOP, RST_MARK, RST_TIME, RST_INTVL};
      cfg_refused <= 1'b0;
    end else begin
      cfg         <= next_cfg;
      cfg_refused <= next_cfg_refused;
    end
  end

  // ---------------------------------------------------------------
  // sweep control
  // ---------------------------------------------------------------
  fss_state_type state;
  fss_state_type next_state;
  logic [16:0]   ms_cnt;
  logic [16:0]   next_ms_cnt;
  logic [TW-1:0] elapsed;
  logic [TW-1:0] next_elapsed;
  logic [TW-1:0] intvl_cnt;
  logic [TW-1:0] next_intvl_cnt;
  logic [TW-1:0] disp_cnt;
  logic [TW-1:0] next_disp_cnt;
  logic          disp_sel;
  logic          next_disp_sel;
  logic          ext_prev;
  logic          ms_tick;
  logic          triggered_oscillation_mode_go;
  logic          sweep_end;
  logic          restart;

  assign ms_tick   = (ms_cnt == 17'(MS_CYCLES - 1));
  assign triggered_oscillation_mode_go   = (external_start_input && !ext_prev) || manual_start_key;
  assign sweep_end = ms_tick && (elapsed + 19'h00001 >= cfg.time_ms);
  // repeat only on an interval boundary after the sweep is over
  assign restart   = ms_tick && (intvl_cnt + 19'h00001 >= cfg.intvl_ms) &&
                     (state != S_SWEEP);

  always_comb begin
    next_state     = state;
    next_elapsed   = elapsed;
    next_intvl_cnt = intvl_cnt;
    next_ms_cnt    = ms_tick ? 17'h00000 : ms_cnt + 17'h00001;
    next_disp_cnt  = disp_cnt;
    next_disp_sel  = disp_sel;
    if (ms_tick && state == S_SWEEP) begin
      next_elapsed = elapsed + 19'h00001;
    end
    if (ms_tick) begin
      next_intvl_cnt = (intvl_cnt + 19'h00001 >= cfg.intvl_ms) ? 19'h00000
                                                               : intvl_cnt + 19'h00001;
      next_disp_cnt  = (disp_cnt + 19'h00001 >= DISP_ALT) ? 19'h00000
                                                          : disp_cnt + 19'h00001;
      next_disp_sel  = (disp_cnt + 19'h00001 >= DISP_ALT) ? !disp_sel : disp_sel;
    end
    case (osc_mode)
      MODE_CONTINUOUS_OSCILLATION_MODE: begin
        if (menu_exit || restart) begin
          next_state     = S_SWEEP;
          next_elapsed   = 19'h00000;
          next_intvl_cnt = 19'h00000;
        end else if (state == S_SWEEP && sweep_end) begin
          next_state = (after_type == AFTER_STOP) ? S_HALT : S_HOLD;
        end
      end
      MODE_TRIGGERED_OSCILLATION_MODE: begin
        // interval plays no part here
        if (triggered_oscillation_mode_go && state != S_SWEEP) begin
          next_state   = S_SWEEP;
          next_elapsed = 19'h00000;
        end else if (state == S_SWEEP && sweep_end) begin
          next_state = (after_type == AFTER_STOP) ? S_HALT : S_HOLD;
        end
      end
      MODE_GATE: begin
        // type and interval play no part here
        if (!external_start_input) begin
          if (state == S_SWEEP || state == S_HOLD) begin
            next_state = S_HALT;
          end
          if (sweep_law == LAW_LOG || state == S_HOLD) begin
            next_elapsed = 19'h00000;
          end
        end else if (state == S_IDLE || state == S_HALT) begin
          next_state = S_SWEEP;
        end else if (state == S_SWEEP && sweep_end) begin
          next_state = S_HOLD;
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (!sweep_enable) begin
      next_state   = S_IDLE;
      next_elapsed = 19'h00000;
    end
    // a new sweep restarts the ms grid so its length is whole
    if (next_state == S_SWEEP && state != S_SWEEP) begin
      next_ms_cnt = 17'h00000;
    end
  end

  // sweep control registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= S_IDLE;
      ms_cnt    <= 17'h00000;
      elapsed   <= 19'h00000;
      intvl_cnt <= 19'h00000;
      disp_cnt  <= 19'h00000;
      disp_sel  <= 1'b0;
      ext_prev  <= 1'b0;
    end else begin
      state     <= next_state;
      ms_cnt    <= next_ms_cnt;
      elapsed   <= next_elapsed;
      intvl_cnt <= next_intvl_cnt;
      disp_cnt  <= next_disp_cnt;
      disp_sel  <= next_disp_sel;
      ext_prev  <= external_start_input;
    end
  end

  // ---------------------------------------------------------------
  // frequency engine: serial divide of span*elapsed by sweep time
  // ---------------------------------------------------------------
  logic [FW-1:0] ep_a;
  logic [FW-1:0] ep_b;
  logic [FW-1:0] span;
  logic          up;
  logic [NW-1:0] num;
  logic [NW-1:0] next_num;
  logic [TW:0]   rem;
  logic [TW:0]   next_rem;
  logic [TW:0]   trial;
  logic [5:0]    bit_cnt;
  logic [5:0]    next_bit_cnt;
  logic [FW-1:0] curve;
  logic [FW-1:0] next_out_freq;
  logic [FW-1:0] next_display;
  logic          next_marker;

  // log law interpolates in the log2 domain
  always_comb begin
    ep_a = (sweep_law == LAW_LOG) ? log2_approx(cfg.start) : cfg.start;
    ep_b = (sweep_law == LAW_LOG) ? log2_approx(cfg.stop) : cfg.stop;
    up   = (cfg.stop >= cfg.start);
    span = up ? ep_b - ep_a : ep_a - ep_b;
  end

  // a fresh divide each ms; the ms period dwarfs its NW steps
  always_comb begin
    next_num     = num;
    next_rem     = rem;
    next_bit_cnt = bit_cnt;
    trial        = {rem[TW-1:0], num[NW-1]};
    next_out_freq = out_freq;
    // divide the progress the sweep is about to reach, not the old one
    if (ms_tick) begin
      next_num     = NW'(span) * NW'(next_elapsed);
      next_rem     = '0;
      next_bit_cnt = 6'(NW);
    end else if (bit_cnt != 6'h00) begin
      next_bit_cnt = bit_cnt - 6'h01;
      if (trial >= {1'b0, cfg.time_ms}) begin
        next_rem = trial - {1'b0, cfg.time_ms};
        next_num = {num[NW-2:0], 1'b1};
      end else begin
        next_rem = trial;
        next_num = {num[NW-2:0], 1'b0};
      end
    end
    // the quotient is whole only after the last step, so use next_num
    curve = up ? ep_a + next_num[FW-1:0] : ep_a - next_num[FW-1:0];
    if (sweep_law == LAW_LOG) begin
      curve = exp2_approx(curve);
    end
    if (bit_cnt == 6'h01 && !ms_tick) begin
      next_out_freq = curve;
    end
    // equal ends give a flat output hold keeps stop
    if (state == S_HOLD || cfg.start == cfg.stop) begin
      next_out_freq = cfg.stop;
    end else if (state == S_IDLE) begin
      next_out_freq = cfg.start;
    end
    // a fresh sweep leaves from start; a stale divide is dropped
    if (next_state == S_SWEEP && state != S_SWEEP && next_elapsed == 19'h00000) begin
      next_out_freq = cfg.start;
      next_bit_cnt  = 6'h00;
    end
    // marker stays up until the output passes the marker point
    next_marker = sweep_marker;
    if (state != S_SWEEP) begin
      next_marker = 1'b0;
    end else if (elapsed == 19'h00000 && !sweep_marker && out_freq == cfg.start) begin
      next_marker = 1'b1;
    end else if (up ? out_freq >= cfg.mark : out_freq <= cfg.mark) begin
      next_marker = 1'b0;
    end
    // readout: alternate when short live when long
    if (state == S_IDLE) begin
      next_display = cfg.start;
    end else if (cfg.time_ms < ONE_S_MS) begin
      next_display = disp_sel ? cfg.stop : cfg.start;
    end else begin
      next_display = out_freq;
    end
  end

  // frequency engine registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      num          <= '0;
      rem          <= '0;
      bit_cnt      <= 6'h00;
      out_freq     <= RST_START;
      display_freq <= RST_START;
      sweep_marker <= 1'b0;
    end else begin
      num          <= next_num;
      rem          <= next_rem;
      bit_cnt      <= next_bit_cnt;
      out_freq     <= next_out_freq;
      display_freq <= next_display;
      sweep_marker <= next_marker;
    end
  end

  assign osc_run    = (state == S_SWEEP) || (state == S_HOLD);
  assign phase_halt = (state == S_HALT);
  assign sweep_sync = (state == S_SWEEP);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_triggered_oscillation_mode_mid;
    osc_mode == MODE_TRIGGERED_OSCILLATION_MODE && state == S_SWEEP && triggered_oscillation_mode_go && !sweep_end && sweep_enable;
  endsequence
  sequence s_timed_end;
    state == S_SWEEP && sweep_end && sweep_enable && osc_mode != MODE_GATE;
  endsequence

  a_triggered_oscillation_mode_ignored: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_triggered_oscillation_mode_mid |=> state == S_SWEEP && ($stable(elapsed) || $past(ms_tick)))
    else $error("trigger restarted a running sweep");
  a_continuous_oscillation_mode_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_timed_end ##0 after_type == AFTER_CONTINUE && !menu_exit |=> osc_run ##1 out_freq == cfg.stop)
    else $error("continue type did not hold stop frequency");
  a_stop_halt: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_timed_end ##0 after_type == AFTER_STOP && !menu_exit |=> phase_halt && !osc_run)
    else $error("stop type did not halt");
  a_menu_start: assert property (@(posedge core_clk) disable iff (!arst_n)
    osc_mode == MODE_CONTINUOUS_OSCILLATION_MODE && menu_exit && sweep_enable |=> sweep_sync && elapsed == 19'h00000)
    else $error("menu exit did not start sweep");
  a_gate_drop: assert property (@(posedge core_clk) disable iff (!arst_n)
    osc_mode == MODE_GATE && osc_run && !external_start_input && sweep_enable |=> phase_halt)
    else $error("gate release did not halt");
  a_log_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
    osc_mode == MODE_GATE && sweep_law == LAW_LOG && !external_start_input |=> elapsed == 19'h00000)
    else $error("log gated sweep kept progress");
  a_short_disp: assert property (@(posedge core_clk) disable iff (!arst_n)
    state != S_IDLE && cfg.time_ms < ONE_S_MS ##1 $stable(cfg) |->
      display_freq == (($past(disp_sel)) ? cfg.stop : cfg.start))
    else $error("short sweep readout not alternating");
  a_sync_level: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(sweep_sync) && $past(sweep_enable) && osc_mode != MODE_GATE |->
      elapsed >= cfg.time_ms)
    else $error("sync fell before the sweep time ran out");
  a_start_range: assert property (@(posedge core_clk) disable iff (!arst_n)
    cfg_write.valid && cfg_write.field == F_START && !wave_narrow |=>
      cfg.start >= FREQ_MIN && cfg.start <= FREQ_MAX_WIDE)
    else $error("start frequency out of range");
  a_edit_refuse: assert property (@(posedge core_clk) disable iff (!arst_n)
    cfg_write.valid && !cfg_write.direct && cfg_write.field == F_TIME &&
      cfg_write.value > TIME_MAX |=> cfg_refused && $stable(cfg.time_ms))
    else $error("digit edit accepted an out-of-range time");
endmodule
`default_nettype wire

// File: verif/fss_ext_src.sv
// Purpose: model of the rear start/gate source
// Assumes: changes just after a core_clk rise
// Notes:   no polarity option, line is active high
`timescale 1ns/1ns
`default_nettype none
module fss_ext_src (
  // clock
  input  wire logic core_clk,
  // start line
  output var  logic external_start_input
);
  initial external_start_input = 1'b0;
  // one-cycle pulse; the rising edge is what starts a sweep
  task automatic pulse();
    @(posedge core_clk) #1 external_start_input = 1'b1;
    @(posedge core_clk) #1 external_start_input = 1'b0;
  endtask
  // gate level, held until changed again
  task automatic gate(input logic level);
    @(posedge core_clk) #1 external_start_input = level;
  endtask
endmodule
`default_nettype wire

// File: verif/frequency_sweep_sequencer_tb.sv
// Purpose: self-checking bench of the sweep sequencer
// Assumes: MS_CYCLES set to 60 so a millisecond is 60 clocks
// Notes:   sweep lengths checked with a small window for tick phase
`timescale 1ns/1ns
`default_nettype none
module frequency_sweep_sequencer_tb;
  import fss_pkg::*;
  localparam int MSC = 60;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic          core_clk;
  logic          arst_n;
  logic          sweep_enable;
  logic          menu_exit;
  fss_mode_type  osc_mode;
  fss_law_type   sweep_law;
  fss_after_type after_type;
  logic          wave_narrow;
  fss_write_type cfg_write;
  logic          external_start_input;
  logic          manual_start_key;
  fss_cfg_type   cfg;
  logic          cfg_refused;
  logic [FW-1:0] out_freq;
  logic [FW-1:0] display_freq;
  logic          osc_run;
  logic          phase_halt;
  logic          sweep_sync;
  logic          sweep_marker;
  int            n_errors;
  int            comparisons;
  int            n;
  int            m;
  logic          rf;
  fss_sequencer #(.MS_CYCLES(MSC)) i_fss_sequencer (
    .core_clk(core_clk), .arst_n(arst_n), .sweep_enable(sweep_enable),
    .menu_exit(menu_exit), .osc_mode(osc_mode), .sweep_law(sweep_law),
    .after_type(after_type), .wave_narrow(wave_narrow), .cfg_write(cfg_write),
    .external_start_input(external_start_input), .manual_start_key(manual_start_key),
    .cfg(cfg), .cfg_refused(cfg_refused), .out_freq(out_freq),
    .display_freq(display_freq), .osc_run(osc_run), .phase_halt(phase_halt),
    .sweep_sync(sweep_sync), .sweep_marker(sweep_marker));
  fss_ext_src i_fss_ext_src (.core_clk(core_clk), .external_start_input(external_start_input));
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [FW-1:0] e, input logic [FW-1:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask
  // window check; an unknown fails since the test must be exactly 1
  task automatic rng(input string nm, input logic [FW-1:0] lo, input logic [FW-1:0] hi,
                     input logic [FW-1:0] g);
    comparisons++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_errors++;
      $display("unexpected %s: expected %0d..%0d, seen %0h", nm, lo, hi, g);
    end
  endtask
  // one settings write; refusal flag sampled in its single cycle
  task automatic wr(input fss_field_type f, input logic d, input logic [FW-1:0] v);
    @(posedge core_clk) #1 cfg_write = '{1'b1, f, d, v};
    @(posedge core_clk) #1 cfg_write.valid = 1'b0;
    rf = cfg_refused;
  endtask
  // bounded wait for the sync level, cycles spent in n
  task automatic ws(input logic lv, input int mx);
    n = 0;
    while (sweep_sync !== lv && n < mx) begin
      @(posedge core_clk) #1;
      n++;
    end
    chk("sweep_sync", 32'(lv), 32'(sweep_sync));
  endtask
  task automatic clk(input int k);
    repeat (k) @(posedge core_clk) #1;
  endtask
  task automatic mode(input fss_mode_type md, input fss_law_type lw, input fss_after_type at);
    sweep_enable = 1'b0;
    clk(2);
    osc_mode = md;
    sweep_law = lw;
    after_type = at;
    sweep_enable = 1'b1;
  endtask
  // watchdog, well beyond the expected run length
  initial begin
    #800000;
    n_errors++;
    end_sim();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    n_errors = 0;
    comparisons = 0;
    arst_n = 1'b0;
    sweep_enable = 1'b0;
    menu_exit = 1'b0;
    osc_mode = MODE_TRIGGERED_OSCILLATION_MODE;
    sweep_law = LAW_LINEAR;
    after_type = AFTER_CONTINUE;
    wave_narrow = 1'b0;
    cfg_write = '0;
    manual_start_key = 1'b0;
    repeat (16) @(posedge core_clk);
    #1 arst_n = 1'b1;
    chk("cfg.start", RST_START, cfg.start);
    chk("cfg.stop", RST_STOP, cfg.stop);
    chk("cfg.mark", RST_MARK, cfg.mark);
    chk("cfg.time_ms", 32'(RST_TIME), 32'(cfg.time_ms));
    chk("cfg.intvl_ms", 32'(RST_INTVL), 32'(cfg.intvl_ms));
    // range handling of the settings
    wr(F_START, 1'b0, 32'h0);
    chk("refused", 32'h1, 32'(rf));
    chk("cfg.start", RST_START, cfg.start);
    wr(F_START, 1'b1, 32'h0);
    chk("cfg.start", FREQ_MIN, cfg.start);
    wr(F_START, 1'b1, 32'hFFFF_FFFF);
    chk("cfg.start", FREQ_MAX_WIDE, cfg.start);
    wave_narrow = !wave_narrow;
    wr(F_STOP, 1'b1, 32'hFFFF_FFFF);
    chk("cfg.stop", FREQ_MAX_NARR, cfg.stop);
    wave_narrow = !wave_narrow;
    wr(F_START, 1'b0, RST_START);
    wr(F_STOP, 1'b0, RST_STOP);
    wr(F_TIME, 1'b1, 32'd600000);
    chk("cfg.time_ms", TIME_MAX, 32'(cfg.time_ms));
    wr(F_TIME, 1'b1, 32'h0);
    chk("cfg.time_ms", TIME_MIN, 32'(cfg.time_ms));
    wr(F_INTVL, 1'b1, 32'd600000);
    chk("cfg.intvl_ms", TIME_MAX, 32'(cfg.intvl_ms));
    wr(F_TIME, 1'b0, 32'd4);
    wr(F_INTVL, 1'b0, 32'd8);
    // linear down sweep below one second: time * stop >= 2 cycles
    wr(F_STOP, 1'b0, 32'd49999);
    chk("refused", 32'h1, 32'(rf));
    wr(F_STOP, 1'b0, 32'd50000);
    chk("cfg.stop", 32'd50000, cfg.stop);
    wr(F_STOP, 1'b0, RST_STOP);
    // continuous, continue after sweep
    mode(MODE_CONTINUOUS_OSCILLATION_MODE, LAW_LINEAR, AFTER_CONTINUE);
    menu_exit = 1'b1;
    clk(1);
    menu_exit = 1'b0;
    ws(1'b1, 2);
    ws(1'b0, 300);
    rng("sweep_len", 4 * MSC - 10, 4 * MSC + 10, 32'(n));
    m = n;
    clk(100);
    chk("osc_run", 32'h1, 32'(osc_run));
    chk("out_freq", RST_STOP, out_freq);
    ws(1'b1, 300);
    rng("repeat_len", 8 * MSC - 10, 8 * MSC + 10, 32'(m + 100 + n));
    clk(100);
    chk("sweep_marker", 32'h1, 32'(sweep_marker));
    chk("display_alt", 32'h1,
        32'(display_freq === RST_START || display_freq === RST_STOP));
    ws(1'b0, 300);
    chk("sweep_marker", 32'h0, 32'(sweep_marker));
    // triggered, stop after sweep; a mid-sweep trigger is ignored
    mode(MODE_TRIGGERED_OSCILLATION_MODE, LAW_LINEAR, AFTER_STOP);
    i_fss_ext_src.pulse();
    ws(1'b1, 3);
    clk(60);
    i_fss_ext_src.pulse();
    ws(1'b0, 300);
    rng("triggered_oscillation_mode_len", 4 * MSC - 14, 4 * MSC + 6, 32'(n + 60));
    clk(1);
    chk("phase_halt", 32'h1, 32'(phase_halt));
    chk("osc_run", 32'h0, 32'(osc_run));
    // watch longer than one repeat interval: no sweep may start
    n = 0;
    repeat (500) begin
      @(posedge core_clk) #1;
      if (sweep_sync !== 1'b0) n++;
    end
    chk("sweep_sync", 32'h0, 32'(n));
    manual_start_key = 1'b1;
    clk(1);
    manual_start_key = 1'b0;
    ws(1'b1, 2);
    ws(1'b0, 300);
    // gated log sweep: hold at stop, halt on release, restart on regate
    mode(MODE_GATE, LAW_LOG, AFTER_STOP);
    i_fss_ext_src.gate(1'b1);
    ws(1'b1, 3);
    ws(1'b0, 300);
    clk(100);
    chk("osc_run", 32'h1, 32'(osc_run));
    chk("out_freq", RST_STOP, out_freq);
    i_fss_ext_src.gate(1'b0);
    clk(2);
    chk("phase_halt", 32'h1, 32'(phase_halt));
    i_fss_ext_src.gate(1'b1);
    ws(1'b1, 3);
    clk(100);
    i_fss_ext_src.gate(1'b0);
    clk(5);
    chk("phase_halt", 32'h1, 32'(phase_halt));
    i_fss_ext_src.gate(1'b1);
    ws(1'b1, 3);
    ws(1'b0, 300);
    rng("regate_len", 4 * MSC - 10, 4 * MSC + 10, 32'(n));
    i_fss_ext_src.gate(1'b0);
    // one second sweep: readout follows the live frequency
    mode(MODE_TRIGGERED_OSCILLATION_MODE, LAW_LINEAR, AFTER_CONTINUE);
    wr(F_TIME, 1'b0, 32'd1000);
    i_fss_ext_src.pulse();
    ws(1'b1, 3);
    clk(20000);
    rng("display_freq", RST_START + 1, RST_STOP - 1, display_freq);
    // sweep function off ends the travel at once
    sweep_enable = 1'b0;
    clk(2);
    chk("sweep_sync", 32'h0, 32'(sweep_sync));
    // equal start and stop: nothing moves
    mode(MODE_TRIGGERED_OSCILLATION_MODE, LAW_LINEAR, AFTER_CONTINUE);
    wr(F_TIME, 1'b0, 32'd4);
    wr(F_STOP, 1'b0, RST_START);
    i_fss_ext_src.pulse();
    clk(100);
    chk("out_freq", RST_START, out_freq);
    clk(300);
    chk("out_freq", RST_START, out_freq);
    end_sim();
  end
endmodule
`default_nettype wire
